// ---- hw/adcpm_defines.svh ----
`ifndef ADCPM_DEFINES_SVH
`define ADCPM_DEFINES_SVH
`define ADCPM_CNT_W        5
`define ADCPM_GLITCH_EDGES 5'h02
`define ADCPM_KEEP_EDGES   5'h0A
`define ADCPM_TRACK_EDGES  5'h0D
`define ADCPM_FULL_EDGES   5'h10
`define ADCPM_LEAD_ZEROS   5'h04
`define ADCPM_RES_W        12
`define ADCPM_PWRUP_NS     1000
`define ADCPM_CLK_NS       4
`define ADCPM_PWRUP_CYC    ((`ADCPM_PWRUP_NS + `ADCPM_CLK_NS - 1) / `ADCPM_CLK_NS)
`define ADCPM_PWRUP_W      9
`endif

// ---- hw/adcpm_pkg.sv ----
package adcpm_pkg;
  typedef enum logic [3:0] {
    ADCPM_UNKNOWN = 4'h1,
    ADCPM_NORMAL  = 4'h2,
    ADCPM_DOWN    = 4'h4,
    ADCPM_WAKING  = 4'h8
  } adcpm_pwr_t;
endpackage : adcpm_pkg

// ---- hw/adcpm_ctrl.sv ----
`include "adcpm_defines.svh"
module adcpm_ctrl (
  input  wire logic                      ref_clk,
  input  wire logic                      rstn,
  input  wire logic                      frame_sel_n,
  input  wire logic                      sclk,
  input  wire logic [`ADCPM_RES_W-1:0]   conv_result,
  output logic                           serial_result_out,
  output logic                           serial_result_oe_n,
  output logic                           hold_q,
  output logic                           powered_q,
  output logic                           mode_known_q,
  output logic                           sample_pulse_q
);
  logic [1:0] cs_sync_q;
  logic [1:0] ck_sync_q;
  logic       cs_d1_q;
  logic       ck_d1_q;
  logic       cs_fall;
  logic       cs_rise;
  logic       ck_fall;
  logic       ck_rise;
  logic [`ADCPM_CNT_W-1:0]   edges_q;
  logic [`ADCPM_RES_W-1:0]   shreg_q;
  logic                      active_q;
  logic                      out_q;
  logic                      oe_n_q;
  logic [`ADCPM_PWRUP_W-1:0] pwr_cnt_q;
  adcpm_pkg::adcpm_pwr_t     pwr_q;

  // pins are asynchronous: two flops before any use
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      cs_sync_q <= 2'h3;
      ck_sync_q <= 2'h0;
      cs_d1_q   <= 1'b1;
      ck_d1_q   <= 1'b0;
    end else begin
      cs_sync_q <= {cs_sync_q[0], frame_sel_n};
      ck_sync_q <= {ck_sync_q[0], sclk};
      cs_d1_q   <= cs_sync_q[1];
      ck_d1_q   <= ck_sync_q[1];
    end
  end
  assign cs_fall = cs_d1_q & ~cs_sync_q[1];
  assign cs_rise = ~cs_d1_q & cs_sync_q[1];
  assign ck_fall = ck_d1_q & ~ck_sync_q[1] & active_q;
  assign ck_rise = ~ck_d1_q & ck_sync_q[1] & active_q;

  // frame sequencing: edge count, shift register, output enable
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      edges_q        <= '0;
      shreg_q        <= '0;
      active_q       <= 1'b0;
      out_q          <= 1'b0;
      oe_n_q         <= 1'b1;
      sample_pulse_q <= 1'b0;
    end else begin
      sample_pulse_q <= 1'b0;
      if (cs_fall) begin
        edges_q        <= '0;
        shreg_q        <= conv_result;
        sample_pulse_q <= 1'b1;
        active_q       <= 1'b1;
        out_q          <= 1'b0;                 // first leading zero
        oe_n_q         <= (pwr_q == adcpm_pkg::ADCPM_DOWN);
      end else if (cs_rise) begin
        active_q <= 1'b0;
        oe_n_q   <= 1'b1;
      end else if (ck_fall) begin
        edges_q <= edges_q + 5'h01;
        if (edges_q + 5'h01 >= `ADCPM_FULL_EDGES) begin
          oe_n_q   <= 1'b1;
          active_q <= 1'b0;
        end else if (edges_q + 5'h01 >= `ADCPM_LEAD_ZEROS) begin
          out_q   <= shreg_q[`ADCPM_RES_W-1];   // msb first
          shreg_q <= {shreg_q[`ADCPM_RES_W-2:0], 1'b0};
        end else begin
          out_q <= 1'b0;
        end
      end
    end
  end
  assign serial_result_out  = out_q;
  assign serial_result_oe_n = oe_n_q;

  // track/hold: starts tracking, as after supply application
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      hold_q <= 1'b0;
    end else if (cs_fall) begin
      hold_q <= 1'b1;
    end else if (pwr_q == adcpm_pkg::ADCPM_WAKING && (ck_fall || ck_rise)
                 && edges_q == '0) begin
      hold_q <= 1'b0;
    end else if (ck_rise && edges_q >= `ADCPM_TRACK_EDGES) begin
      hold_q <= 1'b0;
    end else if (cs_rise && pwr_q != adcpm_pkg::ADCPM_DOWN) begin
      hold_q <= 1'b0;
    end
  end

  // power state; the mode from supply on is unknown
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      pwr_q        <= adcpm_pkg::ADCPM_UNKNOWN;
      mode_known_q <= 1'b0;
      pwr_cnt_q    <= '0;
    end else begin
      case (pwr_q)
        adcpm_pkg::ADCPM_UNKNOWN, adcpm_pkg::ADCPM_NORMAL: begin
          if (cs_rise) begin
            mode_known_q <= 1'b1;
            if (edges_q >= `ADCPM_GLITCH_EDGES && edges_q < `ADCPM_KEEP_EDGES) begin
              pwr_q <= adcpm_pkg::ADCPM_DOWN;
            end else if (edges_q >= `ADCPM_KEEP_EDGES) begin
              pwr_q <= adcpm_pkg::ADCPM_NORMAL;
            end else if (pwr_q == adcpm_pkg::ADCPM_UNKNOWN) begin
              mode_known_q <= 1'b0;             // glitch
            end
          end
        end
        adcpm_pkg::ADCPM_DOWN: begin
          if (cs_fall) begin
            pwr_q     <= adcpm_pkg::ADCPM_WAKING;
            pwr_cnt_q <= '0;
          end
        end
        adcpm_pkg::ADCPM_WAKING: begin
          if (pwr_cnt_q != `ADCPM_PWRUP_W'(`ADCPM_PWRUP_CYC)) begin
            pwr_cnt_q <= pwr_cnt_q + 9'h001;
          end
          if (cs_rise) begin
            pwr_q <= (edges_q >= `ADCPM_KEEP_EDGES) ? adcpm_pkg::ADCPM_NORMAL
                                                    : adcpm_pkg::ADCPM_DOWN;
          end
        end
        default: pwr_q <= adcpm_pkg::ADCPM_UNKNOWN;
      endcase
    end
  end

  // powered in normal mode, or while waking once 1 us has passed
  always_comb begin
    powered_q = (pwr_q == adcpm_pkg::ADCPM_NORMAL) ||
                (pwr_q == adcpm_pkg::ADCPM_WAKING &&
                 pwr_cnt_q == `ADCPM_PWRUP_W'(`ADCPM_PWRUP_CYC));
  end

  // edge-count windows, in counts already seen when the frame rises, except float_a, any count, and end16_a, checked at the 16th clock fall
  pwr_down_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (cs_rise && pwr_q == adcpm_pkg::ADCPM_NORMAL && edges_q >= `ADCPM_GLITCH_EDGES
     && edges_q < `ADCPM_KEEP_EDGES)
    |=> pwr_q == adcpm_pkg::ADCPM_DOWN) else $error("power-down not entered");

  stay_up_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (cs_rise && pwr_q == adcpm_pkg::ADCPM_NORMAL && edges_q >= `ADCPM_KEEP_EDGES)
    |=> pwr_q == adcpm_pkg::ADCPM_NORMAL && oe_n_q) else $error("abort not clean");

  glitch_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (cs_rise && pwr_q == adcpm_pkg::ADCPM_NORMAL && edges_q < `ADCPM_GLITCH_EDGES)
    |=> pwr_q == adcpm_pkg::ADCPM_NORMAL) else $error("glitch powered down");

  float_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    cs_rise |=> oe_n_q) else $error("output not floated");

  wake_fail_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (cs_rise && pwr_q == adcpm_pkg::ADCPM_WAKING && edges_q < `ADCPM_KEEP_EDGES)
    |=> pwr_q == adcpm_pkg::ADCPM_DOWN) else $error("short burst woke device");

  end16_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (ck_fall && !cs_fall && !cs_rise && edges_q == `ADCPM_FULL_EDGES - 5'h01)
    |=> oe_n_q) else $error("no float at 16th edge");

  sequence late_rise_s;
    cs_rise && edges_q >= `ADCPM_KEEP_EDGES;
  endsequence

  sequence wake_start_s;
    cs_fall && pwr_q == adcpm_pkg::ADCPM_DOWN;
  endsequence

  // a wake frame keeps the output floated: no valid data yet
  wake_start_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    wake_start_s |=> pwr_q == adcpm_pkg::ADCPM_WAKING && oe_n_q)
    else $error("wake not started");

  wake_ok_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    pwr_q == adcpm_pkg::ADCPM_WAKING ##0 late_rise_s |=> pwr_q == adcpm_pkg::ADCPM_NORMAL)
    else $error("long wake frame not normal");

  down_stay_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (pwr_q == adcpm_pkg::ADCPM_DOWN && !cs_fall) |=> pwr_q == adcpm_pkg::ADCPM_DOWN)
    else $error("left power-down unasked");

  wake_track_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (pwr_q == adcpm_pkg::ADCPM_WAKING && ck_fall && !cs_fall && edges_q == '0)
    |=> !hold_q) else $error("no track on first edge");

  track_end_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (ck_rise && !cs_fall && edges_q >= `ADCPM_TRACK_EDGES)
    |=> !hold_q) else $error("no track after 13 falls");

  down_unpowered_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    pwr_q == adcpm_pkg::ADCPM_DOWN |-> !powered_q) else $error("powered while down");

  mode_set_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (cs_rise && edges_q >= `ADCPM_GLITCH_EDGES) |=> mode_known_q)
    else $error("mode not established");

  // data bit moves only on a falling edge inside the result field
  shift_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (ck_fall && !cs_fall && !cs_rise && edges_q + 5'h01 >= `ADCPM_LEAD_ZEROS
     && edges_q + 5'h01 < `ADCPM_FULL_EDGES)
    |=> out_q == $past(shreg_q[`ADCPM_RES_W-1])) else $error("result bit wrong");

  pulse_once_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    sample_pulse_q |=> !sample_pulse_q) else $error("sample pulse too long");

  sample_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    cs_fall |=> sample_pulse_q && hold_q) else $error("no sample at frame fall");
  sequence lead_zero_s;
    cs_fall && pwr_q == adcpm_pkg::ADCPM_NORMAL;
  endsequence
  lead_zero_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    lead_zero_s |=> !out_q && !oe_n_q) else $error("first bit not zero");
endmodule : adcpm_ctrl

// ---- verif/adcpm_host.sv ----
module adcpm_host (
  input  wire logic ref_clk,
  output logic      frame_sel_n,
  output logic      sclk
);
  timeunit 1ns;
  timeprecision 1ps;

  // clock parks high outside frames, frame idles high
  initial begin
    frame_sel_n = 1'b1;
    sclk        = 1'b1;
  end

  // n falls per frame, 64 ns period; n of 10 or more keeps power
  task automatic run_frame(input int n);
    frame_sel_n <= 1'b0;
    repeat (8) @(posedge ref_clk);
    for (int k = 0; k < n; k++) begin
      sclk <= 1'b0;
      repeat (8) @(posedge ref_clk);
      sclk <= 1'b1;
      repeat (8) @(posedge ref_clk);
    end
    frame_sel_n <= 1'b1;
    // quiet gap before any next fall
    repeat (16) @(posedge ref_clk);
  endtask : run_frame
endmodule : adcpm_host

// ---- verif/adcpm_ctrl_tb.sv ----
module adcpm_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk = 1'b0;
  logic        rstn = 1'b0;
  logic [11:0] conv_result = 12'h000;
  logic        frame_sel_n, sclk, serial_result_out, serial_result_oe_n;
  logic        hold_q, powered_q, mode_known_q, sample_pulse_q;
  int          fails = 0;
  int          comparisons = 0;
  int          pulses = 0;
  int          seed = 32'h55C3;
  int          lens[7] = '{16, 10, 1, 5, 8, 16, 16};
  logic [6:0]  pwr = 7'h67;
  logic [2:0]  expq[$];

  adcpm_host host (.ref_clk(ref_clk), .frame_sel_n(frame_sel_n), .sclk(sclk));
  adcpm_ctrl dut (
    .ref_clk(ref_clk), .rstn(rstn), .frame_sel_n(frame_sel_n), .sclk(sclk),
    .conv_result(conv_result), .serial_result_out(serial_result_out),
    .serial_result_oe_n(serial_result_oe_n), .hold_q(hold_q), .powered_q(powered_q),
    .mode_known_q(mode_known_q), .sample_pulse_q(sample_pulse_q)
  );

  initial forever #2 ref_clk = ~ref_clk;

  task automatic check(input logic [2:0] seen, input logic [2:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // notes {oe_n, out, hold} per fall; floated data is masked
  task automatic frame(input int n, input bit waking);
    logic [11:0] r;
    r = 12'($random(seed));
    conv_result <= r;
    for (int k = 1; k <= n; k++) begin
      if (waking || k == 16) expq.push_back(3'h4);
      else expq.push_back({1'b0, (k < 4) ? 1'b0 : r[15-k], 1'(k < 14)});
    end
    host.run_frame(n);
  endtask : frame

  // sampled at the rise, well after the output moved on the fall
  always @(posedge sclk) begin
    if (expq.size() > 0)
      check({serial_result_oe_n, serial_result_out & ~serial_result_oe_n, hold_q},
            expq.pop_front());
  end

  always @(posedge ref_clk) begin
    if (sample_pulse_q === 1'b1) pulses++;
  end

  task automatic give_verdict();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict

  initial begin
    repeat (10) @(posedge ref_clk);
    check({serial_result_oe_n, hold_q, mode_known_q}, 3'h4);
    rstn <= 1'b1;
    @(posedge ref_clk);
    $display("test reset done");
    // full, late abort, glitch, power-down, short wake, dummy, valid
    for (int t = 0; t < 7; t++) begin
      frame(lens[t], t == 4 || t == 5);
      check({1'b0, serial_result_oe_n, powered_q}, {2'b01, pwr[t]});
      if (t == 0) check({mode_known_q, 1'b0, 1'(pulses == 1)}, 3'h5);
      $display("test %0d done", t);
    end
    give_verdict();
  end

  // seven frames take about 1330 cycles
  initial begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    give_verdict();
  end
endmodule : adcpm_ctrl_tb
